/* hw/inp_notify.sv */
// interrupt notification, power-off and dormant-hint logic
//
// Function
// - event queue sources fire only on empty to non-empty transitions.
// - realm page-request fires from low bit; non-secure from its condition.
// - sync source fires when a sync completes that asked for an interrupt.
// - global-error source fires when any error of that domain activates.
// - root sources fire on fault address or table config fault records.
// - each source except sync has its own enable; disabled means no pulse, no message.
// - an enabled source pulses its own wired output on a trigger; back-to-back triggers merge.
// - message writes only when supported and target address is non-zero.
// - wired and message signalling may be used at the same time.
// - triggers are edges; no software-clearable pending state exists.
// - reliability interrupts stay independent of notification sources.
// - two extra wired outputs report active granule-protection faults.
// - automatic gating is invisible, keeps state, wakes on a transaction.
// - power-off only after every used domain requested or agreed.
// - stalled transactions at power-down are aborted.
// - wake-up gives a full reset; agent re-initialises before clients.
// - dormant flag set means no cached data and no prefetch running.
// - a notification is seen only after what it announces is seen.
// - disabling a message source waits for its earlier writes.
`timescale 1ns/1ps
module inp_notify
  import inp_pkg::*;
#(
  parameter int ADDR_W     = 64,
  parameter int GERR_W     = 8,
  parameter bit WIRED_IMPL = 1'b1
)(
  input  wire logic                               clk,              // clock
  input  wire logic                               reset_n,          // reset
  input  wire logic [NUM_DOM-1:0]                 evtq_nonempty,    // queues
  input  wire logic                               prq_ns_cond,      // ns prq
  input  wire logic                               prq_r_low_bit,    // rl prq
  input  wire logic [NUM_DOM-1:0]                 sync_done,        // sync
  input  wire logic [NUM_DOM-1:0]                 sync_irq_req,     // asked
  input  wire logic [NUM_DOM-1:0][ADDR_W-1:0]     sync_msg_addr,    // cmd
  input  wire logic [NUM_DOM-1:0][MSG_DATA_W-1:0] sync_msg_data,    // cmd
  input  wire logic [NUM_DOM-1:0][GERR_W-1:0]     global_error_reg, // errs
  input  wire logic                               gpf_active,       // rec
  input  wire logic                               gpt_cfg_active,   // rec
  input  wire logic [NUM_DOM-1:0][CTRL_W-1:0]     irq_ctrl_en,      // en
  input  wire logic [ROOT_W-1:0]                  root_irq_ctrl_en, // en
  input  wire logic                               msg_supported,    // cap
  input  wire logic [NUM_SRC-1:0][ADDR_W-1:0]     msg_addr_cfg,     // cfg
  input  wire logic [NUM_SRC-1:0][MSG_DATA_W-1:0] msg_data_cfg,     // cfg
  output wire logic [NUM_SRC-1:0]                 wired_irq,        // pulses
  output wire logic                               msg_valid,        // req
  input  wire logic                               msg_ready,        // ack
  output wire logic [ADDR_W-1:0]                  msg_addr,         // addr
  output wire logic [MSG_DATA_W-1:0]              msg_data,         // data
  output wire logic [SRC_IDX_W-1:0]               msg_src,          // source
  input  wire logic                               ras_irq_in,       // ras
  output wire logic                               ras_irq_out,      // ras
  input  wire logic [NUM_DOM-1:0]                 pwr_off_req,      // agree
  input  wire logic [NUM_DOM-1:0]                 dom_in_use,       // used
  input  wire logic                               stalled_any,      // stall
  input  wire logic                               wake_evt,         // wake
  input  wire logic                               sw_init_done,     // init
  output wire logic                               abort_stalled,    // abort
  output wire logic                               powered_off,      // off
  output wire logic                               reinit_pending,   // reinit
  output wire logic                               client_en_ok,     // ok
  input  wire logic                               idle_hint,        // idle
  input  wire logic                               txn_arrive,       // txn
  output wire logic                               clk_gate_en,      // gate
  output wire logic                               cache_drop,       // drop
  input  wire logic                               cache_empty,      // empty
  input  wire logic                               prefetch_busy,    // pf
  output wire logic                               dormant_flag      // hint
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_DOM-1:0]                 evtq_prev;
    logic                               prq_ns_prev;
    logic                               prq_r_prev;
    logic [NUM_DOM-1:0][GERR_W-1:0]     gerr_prev;
    logic                               gpf_prev;
    logic                               gpt_prev;
    logic [NUM_SRC-1:0]                 trig;
    logic [NUM_DOM-1:0][ADDR_W-1:0]     sync_addr;
    logic [NUM_DOM-1:0][MSG_DATA_W-1:0] sync_data;
    inp_pwr_t                           pwr;
    logic                               soft_rst;
    logic                               reinit;
    logic                               gated;
    logic                               drop;
    logic                               dormant;
    logic                               ras;
    logic                               abort;
    logic                               busy;
    logic [SRC_IDX_W-1:0]               idx;
    logic [ADDR_W-1:0]                  addr;
    logic [MSG_DATA_W-1:0]              data;
  } inp_state_t;

  inp_state_t st;
  inp_state_t next_st;

  inp_src_if #(.N(NUM_SRC)) sif ();

  logic [NUM_SRC-1:0][ADDR_W-1:0]     src_addr;
  logic [NUM_SRC-1:0][MSG_DATA_W-1:0] src_data;
  logic [NUM_SRC-1:0]                 src_en;
  logic                               run;
  logic                               all_agree;
  logic                               found;
  logic [SRC_IDX_W-1:0]               pick;

  assign run       = (st.pwr == PWR_RUN);
  // domains not in use are counted as agreeing
  assign all_agree = &(pwr_off_req | ~dom_in_use);

  // ---------------------------------------------------------------
  // per-source enables and message targets
  // ---------------------------------------------------------------
  always_comb begin
    src_addr = msg_addr_cfg;
    src_data = msg_data_cfg;
    // sync destination and payload come from the command itself
    src_addr[SRC_SYNC_NS] = st.sync_addr[DOM_NS];
    src_addr[SRC_SYNC_S]  = st.sync_addr[DOM_S];
    src_addr[SRC_SYNC_R]  = st.sync_addr[DOM_R];
    src_data[SRC_SYNC_NS] = st.sync_data[DOM_NS];
    src_data[SRC_SYNC_S]  = st.sync_data[DOM_S];
    src_data[SRC_SYNC_R]  = st.sync_data[DOM_R];
    src_en = '0;
    src_en[SRC_EVTQ_NS] = irq_ctrl_en[DOM_NS][CTRL_EVTQ];
    src_en[SRC_PRQ_NS]  = irq_ctrl_en[DOM_NS][CTRL_PRQ];
    src_en[SRC_GERR_NS] = irq_ctrl_en[DOM_NS][CTRL_GERR];
    src_en[SRC_EVTQ_S]  = irq_ctrl_en[DOM_S][CTRL_EVTQ];
    src_en[SRC_GERR_S]  = irq_ctrl_en[DOM_S][CTRL_GERR];
    src_en[SRC_EVTQ_R]  = irq_ctrl_en[DOM_R][CTRL_EVTQ];
    src_en[SRC_PRQ_R]   = irq_ctrl_en[DOM_R][CTRL_PRQ];
    src_en[SRC_GERR_R]  = irq_ctrl_en[DOM_R][CTRL_GERR];
    src_en[SRC_GPF]     = root_irq_ctrl_en[ROOT_GPF];
    src_en[SRC_GPT_CFG] = root_irq_ctrl_en[ROOT_GPT];
    // sync interrupts are requested per command
    src_en[SRC_SYNC_NS] = 1'b1;
    src_en[SRC_SYNC_S]  = 1'b1;
    src_en[SRC_SYNC_R]  = 1'b1;
  end

  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      assign sif.en[i]     = src_en[i] & run;
      assign sif.msg_ok[i] = msg_supported & (src_addr[i] != '0);
      assign sif.done[i]   = st.busy & msg_ready
                             & (st.idx == SRC_IDX_W'(i));
      inp_src_chan #(
        .IDX        (i),
        .WIRED_IMPL (WIRED_IMPL)
      ) u_chan (
        .clk (clk),
        .sif (sif.chan)
      );
    end
  endgenerate

  assign sif.trig  = st.trig;
  assign sif.rst_n = reset_n & ~st.soft_rst;

  // lowest ready source wins the single message port
  always_comb begin
    found = 1'b0;
    pick  = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (!found && sif.pend[i] && sif.msg_ok[i]) begin
        found = 1'b1;
        pick  = SRC_IDX_W'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    // edges compare the live inputs against last cycle's copies and land
    // a cycle later, so the announcement never overtakes the news
    next_st.evtq_prev   = evtq_nonempty;
    next_st.prq_ns_prev = prq_ns_cond;
    next_st.prq_r_prev  = prq_r_low_bit;
    next_st.gerr_prev   = global_error_reg;
    next_st.gpf_prev    = gpf_active;
    next_st.gpt_prev    = gpt_cfg_active;
    next_st.trig = '0;
    next_st.trig[SRC_EVTQ_NS] = evtq_nonempty[DOM_NS]
                                & ~st.evtq_prev[DOM_NS];
    next_st.trig[SRC_EVTQ_S]  = evtq_nonempty[DOM_S] & ~st.evtq_prev[DOM_S];
    next_st.trig[SRC_EVTQ_R]  = evtq_nonempty[DOM_R] & ~st.evtq_prev[DOM_R];
    next_st.trig[SRC_PRQ_NS]  = prq_ns_cond & ~st.prq_ns_prev;
    next_st.trig[SRC_PRQ_R]   = prq_r_low_bit & ~st.prq_r_prev;
    next_st.trig[SRC_SYNC_NS] = sync_done[DOM_NS]
                                & sync_irq_req[DOM_NS];
    next_st.trig[SRC_SYNC_S]  = sync_done[DOM_S] & sync_irq_req[DOM_S];
    next_st.trig[SRC_SYNC_R]  = sync_done[DOM_R] & sync_irq_req[DOM_R];
    next_st.trig[SRC_GERR_NS] = |(global_error_reg[DOM_NS]
                                  & ~st.gerr_prev[DOM_NS]);
    next_st.trig[SRC_GERR_S]  = |(global_error_reg[DOM_S]
                                  & ~st.gerr_prev[DOM_S]);
    next_st.trig[SRC_GERR_R]  = |(global_error_reg[DOM_R]
                                  & ~st.gerr_prev[DOM_R]);
    // these two feed the extra wired outputs of the top bits
    next_st.trig[SRC_GPF]     = gpf_active & ~st.gpf_prev;
    next_st.trig[SRC_GPT_CFG] = gpt_cfg_active & ~st.gpt_prev;
    for (int d = 0; d < NUM_DOM; d++) begin
      if (sync_done[d] && sync_irq_req[d]) begin
        next_st.sync_addr[d] = sync_msg_addr[d];
        next_st.sync_data[d] = sync_msg_data[d];
      end
    end
    // reliability interrupt has its own path and touches nothing else
    next_st.ras = ras_irq_in;

    // message port
    if (st.busy && msg_ready) begin
      next_st.busy = 1'b0;
    end else if (!st.busy && found) begin
      next_st.busy = 1'b1;
      next_st.idx  = pick;
      next_st.addr = src_addr[pick];
      next_st.data = src_data[pick];
    end

    // power control; the agent has quiesced traffic before asking
    next_st.soft_rst = 1'b0;
    next_st.abort    = 1'b0;
    unique case (st.pwr)
      PWR_RUN: begin
        if (all_agree && (|dom_in_use)) begin
          next_st.pwr = PWR_DRAIN;
        end
      end
      PWR_DRAIN: begin
        next_st.abort = stalled_any;
        if (!stalled_any && !st.busy) begin
          next_st.pwr = PWR_OFF;
        end
      end
      PWR_OFF: begin
        // register inputs are ignored here by agreement
        if (wake_evt) begin
          next_st.soft_rst = 1'b1;
        end
      end
    endcase
    if (sw_init_done) begin
      next_st.reinit = 1'b0;
    end

    // automatic gating keeps every register; only cached data may go
    next_st.drop = 1'b0;
    if (txn_arrive || !run) begin
      next_st.gated = 1'b0;
    end else if (idle_hint && !st.gated) begin
      next_st.gated = 1'b1;
      next_st.drop  = 1'b1;
    end
    next_st.dormant = cache_empty & ~prefetch_busy;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
    end else if (st.soft_rst) begin
      // wake-up behaves as a full reset, then software must re-init
      st        <= '0;
      st.reinit <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wired_irq      = sif.pulse;
  assign msg_valid      = st.busy;
  assign msg_addr       = st.addr;
  assign msg_data       = st.data;
  assign msg_src        = st.idx;
  assign ras_irq_out    = st.ras;
  assign abort_stalled  = st.abort;
  assign powered_off    = (st.pwr == PWR_OFF);
  assign reinit_pending = st.reinit;
  assign client_en_ok   = run & ~st.reinit;
  // a waiting transaction ungates at once, so wake is on demand
  assign clk_gate_en    = st.gated & ~txn_arrive;
  assign cache_drop     = st.drop;
  assign dormant_flag   = st.dormant;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || st.soft_rst);

  evtq_edge_a: assert property (
    evtq_nonempty[DOM_NS] && !st.evtq_prev[DOM_NS]
    |=> st.trig[SRC_EVTQ_NS])
    else $error("event queue fill did not trigger");
  evtq_level_a: assert property (
    evtq_nonempty[DOM_S] && st.evtq_prev[DOM_S]
    |=> !st.trig[SRC_EVTQ_S])
    else $error("event queue triggered while staying non-empty");
  sync_gate_a: assert property (
    !sync_irq_req[DOM_R] |=> !st.trig[SRC_SYNC_R])
    else $error("sync interrupt without request");
  gerr_edge_a: assert property (
    |(global_error_reg[DOM_NS] & ~st.gerr_prev[DOM_NS])
    |=> st.trig[SRC_GERR_NS] ##1 1'b1)
    else $error("global error activation missed");
  msg_target_a: assert property (
    $rose(msg_valid) |-> msg_addr != '0 && msg_supported)
    else $error("message sent to zero address");
  msg_hold_a: assert property (
    msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr)
    && $stable(msg_data))
    else $error("message dropped before accepted");
  ras_indep_a: assert property (
    $past(reset_n) && !$past(st.soft_rst)
    |-> ras_irq_out == $past(ras_irq_in))
    else $error("reliability interrupt disturbed");
  pwr_agree_a: assert property (
    run && !all_agree |=> st.pwr == PWR_RUN)
    else $error("power-off without every domain agreeing");
  abort_a: assert property (
    st.pwr == PWR_DRAIN && stalled_any |=> abort_stalled)
    else $error("stalled transaction not aborted");
  wake_reset_a: assert property (
    st.pwr == PWR_OFF && wake_evt |=> st.soft_rst)
    else $error("wake-up did not reset");
  dormant_a: assert property (
    dormant_flag |-> $past(cache_empty) && !$past(prefetch_busy))
    else $error("dormant flag with cached data or prefetch");
  gate_wake_a: assert property (
    txn_arrive |-> !clk_gate_en)
    else $error("gated while a transaction arrives");

  msg_done_c: cover property (msg_valid && msg_ready);
  both_kinds_c: cover property (|wired_irq && msg_valid);
  power_off_c: cover property (st.pwr == PWR_DRAIN ##1 powered_off);
  gated_c: cover property (clk_gate_en ##[1:8] txn_arrive);

endmodule : inp_notify

/* hw/inp_pkg.sv */
// shared constants and types of the interrupt notify and power block
package inp_pkg;

  // ---------------------------------------------------------------
  // notification sources, one wired output each
  // ---------------------------------------------------------------
  localparam int NUM_SRC     = 13;
  localparam int SRC_IDX_W   = 4;
  localparam int SRC_EVTQ_NS = 0;
  localparam int SRC_EVTQ_S  = 1;
  localparam int SRC_PRQ_NS  = 2;
  localparam int SRC_SYNC_NS = 3;
  localparam int SRC_SYNC_S  = 4;
  localparam int SRC_GERR_NS = 5;
  localparam int SRC_GERR_S  = 6;
  localparam int SRC_EVTQ_R  = 7;
  localparam int SRC_PRQ_R   = 8;
  localparam int SRC_SYNC_R  = 9;
  localparam int SRC_GERR_R  = 10;
  localparam int SRC_GPF     = 11;
  localparam int SRC_GPT_CFG = 12;

  // ---------------------------------------------------------------
  // security domains and interrupt-control enable bit positions
  // ---------------------------------------------------------------
  localparam int NUM_DOM   = 3;
  localparam int DOM_NS    = 0;
  localparam int DOM_S     = 1;
  localparam int DOM_R     = 2;
  localparam int CTRL_W    = 3;
  localparam int CTRL_EVTQ = 0;
  localparam int CTRL_PRQ  = 1;
  localparam int CTRL_GERR = 2;
  localparam int ROOT_W    = 2;
  localparam int ROOT_GPF  = 0;
  localparam int ROOT_GPT  = 1;

  // message payload is a 32-bit data write
  localparam int MSG_DATA_W = 32;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_DRAIN,
    PWR_OFF
  } inp_pwr_t;

endpackage : inp_pkg

/* hw/inp_src_chan.sv */
// one notification source: wired pulse and message request tracking
`timescale 1ns/1ps
module inp_src_chan
  import inp_pkg::*;
#(
  parameter int IDX        = 0,
  parameter bit WIRED_IMPL = 1'b1
)(
  input wire logic clk,          // block clock
  inp_src_if.chan  sif           // controller side
);

  typedef struct packed {
    logic pulse;
    logic pend;
    logic msg_on;
  } inp_chan_t;

  inp_chan_t st;
  inp_chan_t next_st;
  logic      want;

  assign want = sif.en[IDX] & sif.msg_ok[IDX];

  always_comb begin
    next_st = st;
    // back-to-back triggers merge into one pulse
    next_st.pulse = WIRED_IMPL & sif.trig[IDX] & sif.en[IDX]
                    & ~st.pulse;
    // the only way out of pending is completion, never software
    if (st.pend && sif.done[IDX]) begin
      next_st.pend = 1'b0;
    end
    // wired and message paths run side by side; a new trigger wins
    if (sif.trig[IDX] && want) begin
      next_st.pend = 1'b1;
    end
    // a disable only lands once earlier writes have drained
    if (want) begin
      next_st.msg_on = 1'b1;
    end else if (!st.pend) begin
      next_st.msg_on = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!sif.rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sif.pulse[IDX] = st.pulse;
  assign sif.pend[IDX]  = st.pend;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!sif.rst_n);

  pulse_one_cycle_a: assert property (st.pulse |=> !st.pulse)
    else $error("wired pulse longer than one cycle");
  disabled_quiet_a: assert property (
    !sif.en[IDX] |=> !st.pulse && !($rose(st.pend)))
    else $error("disabled source signalled");
  pend_hold_a: assert property (
    st.pend && !sif.done[IDX] |=> st.pend)
    else $error("pending message dropped without completion");
  msg_drain_a: assert property (
    st.msg_on && !want && st.pend |=> st.msg_on)
    else $error("message disable took effect before drain");
  wired_fire_a: assert property (
    sif.trig[IDX] && sif.en[IDX] && !st.pulse && WIRED_IMPL
    |=> st.pulse)
    else $error("enabled trigger gave no wired pulse");

endmodule : inp_src_chan

/* hw/inp_src_if.sv */
// bundle between the notify controller and its per-source channels
`timescale 1ns/1ps
interface inp_src_if
  import inp_pkg::*;
#(
  parameter int N = NUM_SRC
);
  logic [N-1:0] trig;    // one-cycle trigger per source
  logic [N-1:0] en;      // source enable
  logic [N-1:0] msg_ok;  // message write allowed (supported, addr non-zero)
  logic [N-1:0] done;    // message write accepted by the far side
  logic         rst_n;   // block reset including wake-up reset
  logic [N-1:0] pulse;   // wired pulse
  logic [N-1:0] pend;    // message write outstanding

  modport ctl  (output trig, en, msg_ok, done, rst_n, input pulse, pend);
  modport chan (input trig, en, msg_ok, done, rst_n, output pulse, pend);
endinterface : inp_src_if

/* verification/inp_msg_sink.sv */
// far-side sink for message writes, fast or stalling
`timescale 1ns/1ps
module inp_msg_sink (
  input  wire logic        clk,       // clock
  input  wire logic        reset_n,   // reset
  input  wire logic        slow,      // stall before taking
  input  wire logic        msg_valid, // request
  input  wire logic [63:0] msg_addr,  // target
  input  wire logic [31:0] msg_data,  // payload
  input  wire logic [3:0]  msg_src,   // source
  output logic             msg_ready, // accept
  output logic [7:0]       n_rx,      // writes taken
  output logic [99:0]      last       // addr, data, source
);
  logic [3:0] wait_n;
  // ready only answers a held request, so a write is never half-taken
  always @(posedge clk) begin
    if (!reset_n) begin
      msg_ready <= 1'h0;
      n_rx <= 8'h0;
      wait_n <= 4'h0;
    end else if (msg_valid && msg_ready) begin
      n_rx <= n_rx + 8'h1;
      last <= {msg_addr, msg_data, msg_src};
      msg_ready <= 1'h0;
      wait_n <= 4'h0;
    end else if (msg_valid) begin
      wait_n <= wait_n + 4'h1;
      msg_ready <= !slow || wait_n >= 4'h3;
    end
  end
endmodule : inp_msg_sink

/* verification/inp_notify_tb.sv */
// self-checking bench of the notify and power block
`timescale 1ns/1ps
module inp_notify_tb;
  import inp_pkg::*;
  logic clk, reset_n, prq_ns_cond, prq_r_low_bit, gpf_active, gpt_cfg_active;
  logic msg_supported, msg_ready, ras_irq_in, stalled_any, wake_evt;
  logic sw_init_done, idle_hint, txn_arrive, cache_empty, prefetch_busy;
  logic msg_valid, ras_irq_out, abort_stalled, powered_off, reinit_pending;
  logic client_en_ok, clk_gate_en, cache_drop, dormant_flag, slow;
  logic [2:0]        evtq_nonempty, sync_done, sync_irq_req, pwr_off_req;
  logic [2:0]        dom_in_use;
  logic [2:0][63:0]  sync_msg_addr;
  logic [2:0][31:0]  sync_msg_data;
  logic [2:0][7:0]   global_error_reg;
  logic [2:0][2:0]   irq_ctrl_en;
  logic [1:0]        root_irq_ctrl_en;
  logic [12:0][63:0] msg_addr_cfg;
  logic [12:0][31:0] msg_data_cfg;
  logic [12:0]       wired_irq;
  logic [63:0]       msg_addr;
  logic [31:0]       msg_data;
  logic [3:0]        msg_src;
  logic [7:0]        n_rx;
  logic [99:0]       last;
  int err_total, cmp_count, n, first;
  int idx_t[6] = '{0, 1, 8, 10, 11, 12};
  int exp_t[6] = '{1, 0, 1, 1, 1, 1};

  inp_notify i_inp_notify (.*);
  inp_msg_sink i_inp_msg_sink (.clk, .reset_n, .slow, .msg_valid, .msg_addr,
    .msg_data, .msg_src, .msg_ready, .n_rx, .last);

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string nm, input logic [99:0] e, input logic [99:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task watch(input int idx);
    n = 0;
    first = -1;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      #1;
      if (wired_irq[idx] === 1'h1) begin
        n++;
        if (first < 0) first = k;
      end
    end
    @(negedge clk);
  endtask : watch
  task wait_rx(input logic [7:0] t);
    for (int k = 0; k < 60 && n_rx !== t; k++) @(negedge clk);
  endtask : wait_rx
  task give_verdict;
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial begin
    {reset_n, prq_ns_cond, prq_r_low_bit, gpf_active, gpt_cfg_active} = '0;
    {msg_supported, ras_irq_in, stalled_any, wake_evt, sw_init_done} = '0;
    {idle_hint, txn_arrive, cache_empty, prefetch_busy, slow} = '0;
    {evtq_nonempty, sync_done, sync_irq_req, pwr_off_req, dom_in_use} = '0;
    {sync_msg_addr, sync_msg_data, global_error_reg, irq_ctrl_en} = '0;
    {root_irq_ctrl_en, msg_addr_cfg, msg_data_cfg} = '0;
    repeat (20) @(posedge clk);
    @(negedge clk) reset_n = 1'h1;
    @(negedge clk);
    irq_ctrl_en = {3'h7, 3'h6, 3'h7};
    root_irq_ctrl_en = 2'h3;
    msg_supported = 1'h1;
    for (int s = 0; s < 6; s++) begin
      case (s)
        0: evtq_nonempty[0] = 1'h1;
        1: evtq_nonempty[1] = 1'h1;
        2: prq_r_low_bit = 1'h1;
        3: global_error_reg[2] = 8'h04;
        4: gpf_active = 1'h1;
        default: gpt_cfg_active = 1'h1;
      endcase
      watch(idx_t[s]);
      chk("pulse count", exp_t[s], n);
      if (exp_t[s] == 1) chk("pulse delay", 1, first);
    end
    chk("zero addr msg", 8'h0, n_rx);
    evtq_nonempty[0] = 1'h0;
    msg_addr_cfg[0] = 64'h0000_0000_F000_1000;
    msg_data_cfg[0] = 32'hA5A5_0001;
    @(negedge clk) evtq_nonempty[0] = 1'h1;
    wait_rx(8'h1);
    chk("evtq msg", {64'h0000_0000_F000_1000, 32'hA5A5_0001, 4'h0}, last);
    slow = 1'h1;
    sync_msg_addr[1] = 64'h0000_0000_E000_0040;
    sync_msg_data[1] = 32'h0000_5A17;
    sync_irq_req = 3'h2;
    sync_done = 3'h6;
    @(negedge clk) sync_done = 3'h0;
    repeat (20) @(negedge clk);
    chk("sync msg count", 8'h2, n_rx);
    chk("sync msg", {64'h0000_0000_E000_0040, 32'h0000_5A17, 4'h4}, last);
    dom_in_use = 3'h3;
    pwr_off_req = 3'h1;
    stalled_any = 1'h1;
    repeat (6) @(negedge clk);
    chk("partial agree", 1'h0, powered_off);
    pwr_off_req = 3'h3;
    repeat (4) @(negedge clk);
    chk("abort stalled", 1'h1, abort_stalled);
    stalled_any = 1'h0;
    repeat (4) @(negedge clk);
    chk("powered off", 1'h1, powered_off);
    pwr_off_req = 3'h0;
    wake_evt = 1'h1;
    @(negedge clk) wake_evt = 1'h0;
    repeat (4) @(negedge clk);
    chk("wake state", 3'h2, {powered_off, reinit_pending, client_en_ok});
    sw_init_done = 1'h1;
    @(negedge clk) sw_init_done = 1'h0;
    repeat (2) @(negedge clk);
    chk("clients ok", 1'h1, client_en_ok);
    cache_empty = 1'h1;
    repeat (2) @(negedge clk);
    chk("dormant set", 1'h1, dormant_flag);
    prefetch_busy = 1'h1;
    repeat (2) @(negedge clk);
    chk("dormant clear", 1'h0, dormant_flag);
    idle_hint = 1'h1;
    @(negedge clk);
    chk("gate and drop", 2'h3, {clk_gate_en, cache_drop});
    txn_arrive = 1'h1;
    @(negedge clk);
    chk("wake on txn", 2'h0, {clk_gate_en, cache_drop});
    ras_irq_in = 1'h1;
    @(negedge clk);
    chk("ras path", 1'h1, ras_irq_out);
    give_verdict();
  end
endmodule : inp_notify_tb
